// ===== hw/dtcm_cnt_if.sv
// Interface between the control top and one count register pair.
`timescale 1ns/1ps

interface dtcm_cnt_if
  import dtcm_pkg::*;
;
  dtcm_mode_t  mode;
  logic        inc;
  logic        wr_low;
  logic        wr_high;
  logic [7:0]  wdata;
  logic [7:0]  low;
  logic [7:0]  high;
  logic        ovf;

  modport core (input mode, input inc, input wr_low, input wr_high, input wdata,
                output low, output high, output ovf);
  modport ctl (output mode, output inc, output wr_low, output wr_high, output wdata,
               input low, input high, input ovf);
endinterface

// ===== hw/dtcm_counter.sv
// One timer's count register pair with the 13-bit, 16-bit and auto-reload modes.
`timescale 1ns/1ps

module dtcm_counter
  import dtcm_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic resetn,
  dtcm_cnt_if.core  cnt
);
  logic [7:0]  low_r;
  logic [7:0]  high_r;
  logic [7:0]  low_nxt;
  logic [7:0]  high_nxt;
  logic [12:0] c13;
  logic [15:0] c16;
  logic        wrap;

  always_comb begin
    low_nxt = low_r;
    high_nxt = high_r;
    wrap = 1'b0;
    c13 = {high_r, low_r[4:0]} + 13'h0001;
    c16 = {high_r, low_r} + 16'h0001;
    if (cnt.inc) begin
      unique case (cnt.mode)
        MODE_13: begin
          low_nxt = {low_r[7:5], c13[4:0]};
          high_nxt = c13[12:5];
          wrap = ({high_r, low_r[4:0]} == MODE13_MAX);
        end
        MODE_16: begin
          {high_nxt, low_nxt} = c16;
          wrap = &{high_r, low_r};
        end
        MODE_RLD: begin
          low_nxt = (&low_r) ? high_r : (low_r + 8'h01);
          wrap = &low_r;
        end
        MODE_STOP: wrap = 1'b0;
      endcase
    end
    // A software write in the same cycle wins over the count.
    if (cnt.wr_low) low_nxt = cnt.wdata;
    if (cnt.wr_high) high_nxt = cnt.wdata;
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      low_r <= REG_RST;
      high_r <= REG_RST;
    end else begin
      low_r <= low_nxt;
      high_r <= high_nxt;
    end
  end

  assign cnt.low = low_r;
  assign cnt.high = high_r;
  assign cnt.ovf = wrap && !cnt.wr_low && !cnt.wr_high;

  a_mode0_wrap: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (cnt.inc && cnt.mode == MODE_13 && {high_r, low_r[4:0]} == 13'h1fff && !cnt.wr_low && !cnt.wr_high)
    |-> cnt.ovf ##1 (high_r == 8'h00 && low_r[4:0] == 5'h00))
    else $error("mode 0 count did not wrap to zero");
  a_mode1_wrap: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (cnt.inc && cnt.mode == MODE_16 && cnt.ovf) |=> ({high_r, low_r} == 16'h0000))
    else $error("mode 1 count did not wrap to zero");
  a_mode2_reload: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (cnt.inc && cnt.mode == MODE_RLD && low_r == 8'hff && !cnt.wr_low && !cnt.wr_high)
    |-> cnt.ovf ##1 (low_r == $past(high_r)))
    else $error("mode 2 did not reload from the high byte");
endmodule

// ===== hw/dtcm_ext_flag.sv
// One external interrupt flag, edge or level sensitive.
`timescale 1ns/1ps

module dtcm_ext_flag
  import dtcm_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic pin_level,
  input  wire logic pin_fall,
  input  wire logic edge_mode,
  input  wire logic vec_clr,
  input  wire logic sw_wr,
  input  wire logic sw_val,
  output wire logic flag
);
  logic flag_r;

  // A fall seen in the cycle of a clear still sets the flag.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      flag_r <= BIT_RST;
    end else if (!edge_mode) begin
      flag_r <= !pin_level;
    end else if (pin_fall) begin
      flag_r <= 1'b1;
    end else if (vec_clr) begin
      flag_r <= 1'b0;
    end else if (sw_wr) begin
      flag_r <= sw_val;
    end
  end

  assign flag = flag_r;

  a_level_follow: assert property (
    @(posedge core_clk) disable iff (!resetn)
    !edge_mode |=> (flag_r == !$past(pin_level)))
    else $error("level flag did not follow the pin");
  a_edge_set: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (edge_mode && pin_fall) |=> flag_r)
    else $error("edge flag not set by a falling edge");
  a_vec_clear: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (edge_mode && vec_clr && !pin_fall) |=> !flag_r)
    else $error("edge flag not cleared on vectoring");
endmodule

// ===== hw/dtcm_pkg.sv
// Package with register addresses, field positions, reset values and count constants of the dual timer.
package dtcm_pkg;

  typedef logic [1:0] dtcm_mode_t;

  localparam logic [7:0] TCS_ADDR = 8'h88;
  localparam logic [7:0] TMS_ADDR = 8'h89;
  localparam logic [7:0] TAL_ADDR = 8'h8a;
  localparam logic [7:0] TBL_ADDR = 8'h8b;
  localparam logic [7:0] TAH_ADDR = 8'h8c;
  localparam logic [7:0] TBH_ADDR = 8'h8d;
  localparam logic [7:0] CRC_ADDR = 8'h8e;

  localparam int TCS_TBOVF = 7;
  localparam int TCS_TBRUN = 6;
  localparam int TCS_TAOVF = 5;
  localparam int TCS_TARUN = 4;
  localparam int TCS_EBFLG = 3;
  localparam int TCS_EBTYP = 2;
  localparam int TCS_EAFLG = 1;
  localparam int TCS_EATYP = 0;
  localparam int TMS_TBGATE = 7;
  localparam int TMS_TBSRC = 6;
  localparam int TMS_TBMODE = 4;
  localparam int TMS_TAGATE = 3;
  localparam int TMS_TASRC = 2;
  localparam int TMS_TAMODE = 0;
  localparam int CRC_TBPRE = 4;
  localparam int CRC_TAPRE = 3;

  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic       BIT_RST = 1'b0;

  localparam dtcm_mode_t MODE_13 = 2'b00;
  localparam dtcm_mode_t MODE_16 = 2'b01;
  localparam dtcm_mode_t MODE_RLD = 2'b10;
  localparam dtcm_mode_t MODE_STOP = 2'b11;
  localparam logic [12:0] MODE13_MAX = 13'h1fff;

  localparam int PIN_N = 4;
  localparam int PIN_EXT_A = 0;
  localparam int PIN_EXT_B = 1;
  localparam int PIN_CNT_A = 2;
  localparam int PIN_CNT_B = 3;
  localparam logic [3:0] PIN_RST = 4'hf;

  localparam int PRESC_SLOW_DIV = 12;
  localparam int PRESC_FAST_DIV = 4;
  localparam logic [3:0] PRESC_RST = 4'h0;
  localparam logic [3:0] PRESC_LAST = 4'(PRESC_SLOW_DIV - 1);
  localparam logic [1:0] FAST_LAST = 2'(PRESC_FAST_DIV - 1);
endpackage

// ===== hw/dtcm_top.sv
// Top of the dual timer/counter: register port, pin capture, prescaler, control and flags.
`timescale 1ns/1ps

module dtcm_top
  import dtcm_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic       sfr_rd,
  input  wire logic [7:0] sfr_wdata,
  output wire logic [7:0] sfr_rdata,
  input  wire logic       vec_timer_a,
  input  wire logic       vec_timer_b,
  input  wire logic       vec_ext_a,
  input  wire logic       vec_ext_b,
  input  wire logic       ext_irq_a_pin,
  input  wire logic       ext_irq_b_pin,
  input  wire logic       timer_a_count_pin,
  input  wire logic       timer_b_count_pin,
  output wire logic       timer_a_overflow_pulse,
  output wire logic       timer_b_overflow_pulse,
  output wire logic       timer_a_overflow_flag,
  output wire logic       timer_b_overflow_flag,
  output wire logic       ext_irq_a_flag,
  output wire logic       ext_irq_b_flag
);
  // **********************************************************
  // Functions
  // **********************************************************

  function automatic logic sfr_hit(input logic [7:0] addr, input logic [7:0] reg_addr,
                                   input logic strobe);
    return strobe && (addr == reg_addr);
  endfunction

  // One count event for a timer: source choice, prescale choice and gating.
  function automatic logic advance(input logic run, input logic gate, input logic irq_lvl,
                                   input logic src, input logic fast, input logic fall,
                                   input logic t_fast, input logic t_slow);
    logic ev;
    ev = src ? fall : (fast ? t_fast : t_slow);
    return run && (!gate || irq_lvl) && ev;
  endfunction

  // **********************************************************
  // Declarations
  // **********************************************************

  logic [PIN_N-1:0] pin_meta_r;
  logic [PIN_N-1:0] pin_sync_r;
  logic [PIN_N-1:0] pin_prev_r;
  logic [PIN_N-1:0] pin_fall;
  logic [PIN_N-1:0] pins_in;
  logic [3:0]       presc_r;
  logic             tick_slow;
  logic             tick_fast;
  logic [7:0]       tms_r;
  logic             pre_a_r;
  logic             pre_b_r;
  logic             run_a_r;
  logic             run_b_r;
  logic             typ_a_r;
  logic             typ_b_r;
  logic             tf_a_r;
  logic             tf_b_r;
  logic             pulse_a_r;
  logic             pulse_b_r;
  logic [7:0]       rdata_r;
  logic [7:0]       rd_mux;
  logic             ie_a;
  logic             ie_b;
  logic             wr_tcs;
  logic             wr_tms;
  logic             wr_crc;

  dtcm_cnt_if cnt_a ();
  dtcm_cnt_if cnt_b ();

  // **********************************************************
  // Pin capture
  // **********************************************************

  assign pins_in = {timer_b_count_pin, timer_a_count_pin, ext_irq_b_pin, ext_irq_a_pin};

  // Idle-high reset values keep a released reset from looking like a falling edge.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pin_meta_r <= PIN_RST;
      pin_sync_r <= PIN_RST;
      pin_prev_r <= PIN_RST;
    end else begin
      pin_meta_r <= pins_in;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  assign pin_fall = pin_prev_r & ~pin_sync_r;

  // **********************************************************
  // Prescaler
  // **********************************************************

  // One shared divider serves both rates, so the two timers stay in step.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      presc_r <= PRESC_RST;
    end else if (presc_r == PRESC_LAST) begin
      presc_r <= PRESC_RST;
    end else begin
      presc_r <= presc_r + 4'h1;
    end
  end

  assign tick_slow = (presc_r == PRESC_LAST);
  assign tick_fast = (presc_r[1:0] == FAST_LAST);

  // **********************************************************
  // Register writes
  // **********************************************************

  assign wr_tcs = sfr_hit(sfr_addr, TCS_ADDR, sfr_wr);
  assign wr_tms = sfr_hit(sfr_addr, TMS_ADDR, sfr_wr);
  assign wr_crc = sfr_hit(sfr_addr, CRC_ADDR, sfr_wr);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tms_r <= REG_RST;
    end else if (wr_tms) begin
      tms_r <= sfr_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pre_a_r <= BIT_RST;
      pre_b_r <= BIT_RST;
    end else if (wr_crc) begin
      pre_a_r <= sfr_wdata[CRC_TAPRE];
      pre_b_r <= sfr_wdata[CRC_TBPRE];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      run_a_r <= BIT_RST;
      run_b_r <= BIT_RST;
      typ_a_r <= BIT_RST;
      typ_b_r <= BIT_RST;
    end else if (wr_tcs) begin
      run_a_r <= sfr_wdata[TCS_TARUN];
      run_b_r <= sfr_wdata[TCS_TBRUN];
      typ_a_r <= sfr_wdata[TCS_EATYP];
      typ_b_r <= sfr_wdata[TCS_EBTYP];
    end
  end

  // **********************************************************
  // Timers
  // **********************************************************

  // Split mode of timer A is not built: code 3 halts timer A like timer B.
  assign cnt_a.mode = tms_r[TMS_TAMODE +: 2];
  assign cnt_b.mode = tms_r[TMS_TBMODE +: 2];
  assign cnt_a.inc = advance(run_a_r, tms_r[TMS_TAGATE], pin_sync_r[PIN_EXT_A], tms_r[TMS_TASRC],
                             pre_a_r, pin_fall[PIN_CNT_A], tick_fast, tick_slow);
  assign cnt_b.inc = advance(run_b_r, tms_r[TMS_TBGATE], pin_sync_r[PIN_EXT_B], tms_r[TMS_TBSRC],
                             pre_b_r, pin_fall[PIN_CNT_B], tick_fast, tick_slow);
  assign cnt_a.wr_low = sfr_hit(sfr_addr, TAL_ADDR, sfr_wr);
  assign cnt_a.wr_high = sfr_hit(sfr_addr, TAH_ADDR, sfr_wr);
  assign cnt_b.wr_low = sfr_hit(sfr_addr, TBL_ADDR, sfr_wr);
  assign cnt_b.wr_high = sfr_hit(sfr_addr, TBH_ADDR, sfr_wr);
  assign cnt_a.wdata = sfr_wdata;
  assign cnt_b.wdata = sfr_wdata;

  dtcm_counter u_cnt_a (
    .core_clk (core_clk),
    .resetn   (resetn),
    .cnt      (cnt_a)
  );

  dtcm_counter u_cnt_b (
    .core_clk (core_clk),
    .resetn   (resetn),
    .cnt      (cnt_b)
  );

  // **********************************************************
  // Overflow pulses and flags
  // **********************************************************

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pulse_a_r <= BIT_RST;
      pulse_b_r <= BIT_RST;
    end else begin
      pulse_a_r <= cnt_a.ovf;
      pulse_b_r <= cnt_b.ovf;
    end
  end

  // Overflow wins over a software or vector clear in the same cycle.
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tf_a_r <= BIT_RST;
    end else if (cnt_a.ovf) begin
      tf_a_r <= 1'b1;
    end else if (wr_tcs) begin
      tf_a_r <= sfr_wdata[TCS_TAOVF];
    end else if (vec_timer_a) begin
      tf_a_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      tf_b_r <= BIT_RST;
    end else if (cnt_b.ovf) begin
      tf_b_r <= 1'b1;
    end else if (wr_tcs) begin
      tf_b_r <= sfr_wdata[TCS_TBOVF];
    end else if (vec_timer_b) begin
      tf_b_r <= 1'b0;
    end
  end

  // **********************************************************
  // External interrupt flags
  // **********************************************************

  dtcm_ext_flag u_ext_a (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .pin_level (pin_sync_r[PIN_EXT_A]),
    .pin_fall  (pin_fall[PIN_EXT_A]),
    .edge_mode (typ_a_r),
    .vec_clr   (vec_ext_a),
    .sw_wr     (wr_tcs),
    .sw_val    (sfr_wdata[TCS_EAFLG]),
    .flag      (ie_a)
  );

  dtcm_ext_flag u_ext_b (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .pin_level (pin_sync_r[PIN_EXT_B]),
    .pin_fall  (pin_fall[PIN_EXT_B]),
    .edge_mode (typ_b_r),
    .vec_clr   (vec_ext_b),
    .sw_wr     (wr_tcs),
    .sw_val    (sfr_wdata[TCS_EBFLG]),
    .flag      (ie_b)
  );

  // **********************************************************
  // Register reads
  // **********************************************************

  always_comb begin
    rd_mux = REG_RST;
    unique case (sfr_addr)
      TCS_ADDR: rd_mux = {tf_b_r, run_b_r, tf_a_r, run_a_r, ie_b, typ_b_r, ie_a, typ_a_r};
      TMS_ADDR: rd_mux = tms_r;
      TAL_ADDR: rd_mux = cnt_a.low;
      TBL_ADDR: rd_mux = cnt_b.low;
      TAH_ADDR: rd_mux = cnt_a.high;
      TBH_ADDR: rd_mux = cnt_b.high;
      CRC_ADDR: begin
        rd_mux[CRC_TAPRE] = pre_a_r;
        rd_mux[CRC_TBPRE] = pre_b_r;
      end
      default: rd_mux = REG_RST;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_r <= REG_RST;
    end else if (sfr_rd) begin
      rdata_r <= rd_mux;
    end
  end

  assign sfr_rdata = rdata_r;
  assign timer_a_overflow_pulse = pulse_a_r;
  assign timer_b_overflow_pulse = pulse_b_r;
  assign timer_a_overflow_flag = tf_a_r;
  assign timer_b_overflow_flag = tf_b_r;
  assign ext_irq_a_flag = ie_a;
  assign ext_irq_b_flag = ie_b;

  // **********************************************************
  // Assertions
  // **********************************************************

  a_pulse_one_cycle: assert property (
    @(posedge core_clk) disable iff (!resetn)
    $rose(pulse_a_r) |=> !pulse_a_r)
    else $error("timer A overflow pulse longer than one cycle");
  a_flag_with_pulse: assert property (
    @(posedge core_clk) disable iff (!resetn)
    pulse_b_r |-> tf_b_r)
    else $error("timer B flag not set with its overflow pulse");
  a_run_halts: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (!run_a_r && !cnt_a.wr_low && !cnt_a.wr_high) |=> $stable({cnt_a.high, cnt_a.low}))
    else $error("timer A counted while halted");
  a_gate_holds: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (tms_r[TMS_TBGATE] && !pin_sync_r[PIN_EXT_B] && !cnt_b.wr_low && !cnt_b.wr_high)
    |=> $stable({cnt_b.high, cnt_b.low}))
    else $error("timer B counted with gate closed");
  a_mode3_stops: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (cnt_b.mode == MODE_STOP && !cnt_b.wr_low && !cnt_b.wr_high) |=> $stable({cnt_b.high, cnt_b.low}))
    else $error("timer B counted in the stop code");
  a_pin_counts: assert property (
    @(posedge core_clk) disable iff (!resetn)
    (run_b_r && !tms_r[TMS_TBGATE] && tms_r[TMS_TBSRC] && cnt_b.mode == MODE_16
     && pin_fall[PIN_CNT_B] && !cnt_b.wr_low && !cnt_b.wr_high)
    |=> ({cnt_b.high, cnt_b.low} == 16'($past({cnt_b.high, cnt_b.low}) + 16'h0001)))
    else $error("timer B missed a count pin edge");
  a_slow_period: assert property (
    @(posedge core_clk) disable iff (!resetn)
    tick_slow |=> !tick_slow [*8] ##1 !tick_slow [*3] ##1 tick_slow)
    else $error("slow prescale period is not twelve cycles");
  a_fast_period: assert property (
    @(posedge core_clk) disable iff (!resetn)
    tick_fast |=> !tick_fast [*3] ##1 tick_fast)
    else $error("fast prescale period is not four cycles");
endmodule

// ===== verif/dtcm_pin_model.sv
// Behavioural model of the count and interrupt pins that face the timer block.
`timescale 1ns/1ps

module dtcm_pin_model
  import dtcm_pkg::*;
(
  input  wire logic       core_clk,
  output logic      [3:0] pins
);
  // All four lines idle high like pulled-up pins; a low start would look like a fall.
  initial pins = PIN_RST;

  // Levels are held five cycles so the two-flop synchroniser always sees them.
  task automatic drive(input int idx, input logic lvl);
    @(posedge core_clk);
    pins[idx] <= lvl;
    repeat (5) @(posedge core_clk);
  endtask

  task automatic fall(input int idx);
    drive(idx, 1'b0);
    drive(idx, 1'b1);
  endtask
endmodule

// ===== verif/tb_dual_timer_counter_modes.sv
// Self-checking testbench of the dual timer/counter through its register port and pins.
`timescale 1ns/1ps

module tb_dual_timer_counter_modes
  import dtcm_pkg::*;
;
  logic       core_clk;
  logic       resetn;
  logic [7:0] sfr_addr;
  logic       sfr_wr;
  logic       sfr_rd;
  logic [7:0] sfr_wdata;
  wire  [7:0] sfr_rdata;
  logic [3:0] vec;
  wire  [3:0] pins;
  wire        pulse_a;
  wire        pulse_b;
  wire        flag_a;
  wire        flag_b;
  wire        eflag_a;
  wire        eflag_b;
  int         num_errors;
  int         checks;
  int         pb;
  int         n;

  dtcm_top i_dtcm_top (.core_clk, .resetn, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .vec_timer_a(vec[0]), .vec_timer_b(vec[1]), .vec_ext_a(vec[2]), .vec_ext_b(vec[3]),
    .ext_irq_a_pin(pins[PIN_EXT_A]), .ext_irq_b_pin(pins[PIN_EXT_B]),
    .timer_a_count_pin(pins[PIN_CNT_A]), .timer_b_count_pin(pins[PIN_CNT_B]),
    .timer_a_overflow_pulse(pulse_a), .timer_b_overflow_pulse(pulse_b),
    .timer_a_overflow_flag(flag_a), .timer_b_overflow_flag(flag_b),
    .ext_irq_a_flag(eflag_a), .ext_irq_b_flag(eflag_b));

  dtcm_pin_model i_dtcm_pin_model (.core_clk, .pins);

  always #2 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (pulse_b === 1'b1) begin
      pb++;
    end
  end

  // ****************************************
  // Register port and check helpers
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_wdata <= v;
    sfr_wr <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Read data lands at the edge that takes the strobe, so it is picked up just after it.
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
    @(posedge core_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    #1;
    chk(sfr_rdata & m, exp);
  endtask

  task automatic vpulse(input int i);
    @(posedge core_clk);
    vec[i] <= 1'b1;
    @(posedge core_clk);
    vec[i] <= 1'b0;
    #1;
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wait_pulse(output int cyc);
    for (cyc = 1; cyc <= 200; cyc++) begin
      @(posedge core_clk);
      #1;
      if (pulse_a === 1'b1) begin
        return;
      end
    end
    num_errors++;
    report_and_stop();
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    core_clk = 1'b0;
    resetn = 1'b0;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    vec = 4'h0;
    repeat (16) @(posedge core_clk);
    resetn <= 1'b1;
    for (int a = 8'h88; a <= 8'h8f; a++) rchk(8'(a), 8'h00);
    wr(8'h8f, 8'hff);
    rchk(8'h8f, 8'h00);
    wr(TMS_ADDR, 8'ha5);
    rchk(TMS_ADDR, 8'ha5);
    $display("test done: reset and map");

    wr(TAH_ADDR, 8'hff);
    wr(TAL_ADDR, 8'hfe);
    wr(TMS_ADDR, 8'h01);
    wr(CRC_ADDR, 8'h08);
    wr(TCS_ADDR, 8'h10);
    wait_pulse(n);
    @(posedge core_clk);
    #1;
    chk({7'h0, pulse_a}, 8'h00);
    chk({7'h0, flag_a}, 8'h01);
    wr(TCS_ADDR, 8'h20);
    rchk(TAH_ADDR, 8'h00);
    rchk(TAL_ADDR, 8'h00);
    rchk(TCS_ADDR, 8'h20);
    $display("test done: sixteen-bit wrap");

    wr(TAH_ADDR, 8'hfe);
    wr(TAL_ADDR, 8'hfe);
    wr(TMS_ADDR, 8'h02);
    wr(TCS_ADDR, 8'h10);
    wait_pulse(n);
    wait_pulse(n);
    chk(8'(n), 8'h08);
    chk({7'h0, flag_a}, 8'h01);
    wr(CRC_ADDR, 8'h00);
    wait_pulse(n);
    wait_pulse(n);
    chk(8'(n), 8'h18);
    wr(TCS_ADDR, 8'h20);
    rchk(TAL_ADDR, 8'hfe);
    vpulse(0);
    chk({7'h0, flag_a}, 8'h00);
    $display("test done: auto-reload and prescale");

    wr(TBH_ADDR, 8'hff);
    wr(TBL_ADDR, 8'hfe);
    wr(TMS_ADDR, 8'h40);
    wr(TCS_ADDR, 8'h40);
    i_dtcm_pin_model.fall(PIN_CNT_B);
    chk(8'(pb), 8'h00);
    rchk(TBL_ADDR, 8'h1f, 8'h1f);
    i_dtcm_pin_model.fall(PIN_CNT_B);
    chk(8'(pb), 8'h01);
    rchk(TBH_ADDR, 8'h00);
    rchk(TBL_ADDR, 8'h00, 8'h1f);
    rchk(TCS_ADDR, 8'hc0);
    chk({7'h0, flag_b}, 8'h01);
    vpulse(1);
    chk({7'h0, flag_b}, 8'h00);
    $display("test done: thirteen-bit count pin");

    wr(TMS_ADDR, 8'hd0);
    wr(TBL_ADDR, 8'h00);
    wr(TBH_ADDR, 8'h00);
    wr(TCS_ADDR, 8'h40);
    i_dtcm_pin_model.drive(PIN_EXT_B, 1'b0);
    chk({7'h0, eflag_b}, 8'h01);
    i_dtcm_pin_model.fall(PIN_CNT_B);
    rchk(TBL_ADDR, 8'h00);
    i_dtcm_pin_model.drive(PIN_EXT_B, 1'b1);
    i_dtcm_pin_model.fall(PIN_CNT_B);
    rchk(TBL_ADDR, 8'h01);
    wr(TCS_ADDR, 8'h00);
    i_dtcm_pin_model.fall(PIN_CNT_B);
    rchk(TBL_ADDR, 8'h01);
    wr(TMS_ADDR, 8'h70);
    wr(TCS_ADDR, 8'h40);
    i_dtcm_pin_model.fall(PIN_CNT_B);
    rchk(TBL_ADDR, 8'h01);
    wr(TMS_ADDR, 8'h50);
    i_dtcm_pin_model.drive(PIN_EXT_B, 1'b0);
    i_dtcm_pin_model.fall(PIN_CNT_B);
    rchk(TBL_ADDR, 8'h02);
    i_dtcm_pin_model.drive(PIN_EXT_B, 1'b1);
    wr(TCS_ADDR, 8'h00);
    $display("test done: gate, run and stop");

    wr(TCS_ADDR, 8'h01);
    i_dtcm_pin_model.fall(PIN_EXT_A);
    chk({7'h0, eflag_a}, 8'h01);
    vpulse(2);
    chk({7'h0, eflag_a}, 8'h00);
    i_dtcm_pin_model.fall(PIN_EXT_A);
    wr(TCS_ADDR, 8'h01);
    rchk(TCS_ADDR, 8'h01);
    wr(TCS_ADDR, 8'h00);
    i_dtcm_pin_model.drive(PIN_EXT_A, 1'b0);
    chk({7'h0, eflag_a}, 8'h01);
    wr(TCS_ADDR, 8'h00);
    rchk(TCS_ADDR, 8'h02);
    i_dtcm_pin_model.drive(PIN_EXT_A, 1'b1);
    chk({7'h0, eflag_a}, 8'h00);
    $display("test done: external flags");
    report_and_stop();
  end
endmodule
